// file: core/e1tx_encoder.sv
// e1 transmit system interface, line encoder, clock loss and strap control
`timescale 1ns/10ps
`default_nettype none
module e1tx_encoder
  import e1tx_pkg::*;
(
  // clocks and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tx_bit_clock,
  // hardware pins
  input  wire logic       hw_reset_n,
  input  wire logic       driver_float_enable,
  input  wire logic       control_select_hi,
  input  wire logic       control_select_lo,
  input  wire logic       serial_edge_choice,
  input  wire logic       pulse_shape_pin,
  input  wire logic [1:0] path_operation_straps,
  input  wire logic       tx_clock_loss_mask,
  // system transmit data
  input  wire logic       tx_data_pos_rail,
  input  wire logic       tx_data_neg_rail,
  // register port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  // line side
  output var  logic       line_output_pos,
  output var  logic       line_output_neg,
  output var  logic       line_output_oe,
  // status and decoded control
  output var  logic       internal_reset,
  output var  logic [3:0] ctl_mode,
  output var  logic       serial_fall_edge,
  output var  logic       pulse_user_template,
  output var  logic [1:0] path_mode,
  output var  logic       tx_clock_lost,
  output var  logic       tx_clock_loss_irq
);

  localparam int PIN_W = 9;

  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic             tog_s1;
    logic             tog_s2;
    logic             tog_s3;
    logic [1:0]       boot;
    logic [7:0]       rst_cnt;
    logic             hw_rst;
    logic             irst;
    e1tx_ctl_t        mode;
    logic [7:0]       tx_path_config_zero;
    logic [7:0]       tcf1;
    logic [6:0]       loss_cnt;
    logic             lost;
    logic             irq;
    logic             oe;
    logic [7:0]       rdata;
    logic [3:0]       cfg;
    logic [3:0]       cfg_hold;
    logic             cfg_req;
    logic             cfg_ack_s1;
    logic             cfg_ack_s2;
    logic             user_tpl;
    logic [1:0]       pmode;
    logic             sfall;
  } e1tx_core_t;

  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic [3:0] cfg;
    logic [1:0] dat;
    logic       tog;
    logic       pos;
    logic       neg;
  } e1tx_link_t;

  // cfg bit order shared across the crossing
  localparam int CFG_AMI  = 0;
  localparam int CFG_DUAL = 1;
  localparam int CFG_INV  = 2;
  localparam int CFG_RISE = 3;

  e1tx_core_t c_q;
  e1tx_core_t c_n;
  e1tx_link_t l_q;
  e1tx_link_t l_n;
  logic [1:0] neg_cap;
  logic       cod_pos;
  logic       cod_neg;

  // pin field positions after the synchroniser
  logic       p_rstn;
  logic       p_float;
  logic [1:0] p_sel;
  logic       p_serial_edge_choice;
  logic       p_pulse_shape_pin;
  logic [1:0] p_path;
  logic       p_mask;

  assign {p_rstn, p_float, p_sel, p_serial_edge_choice, p_pulse_shape_pin, p_path, p_mask} =
    c_q.pin_s2;

  // master clock domain
  always_comb
  begin
    logic tx_edge;
    logic sw_mode;
    tx_edge = c_q.tog_s2 ^ c_q.tog_s3;
    sw_mode = (c_q.mode != E1TX_CTL_HW);
    c_n = c_q;
    c_n.pin_s1 = {hw_reset_n, driver_float_enable, control_select_hi,
                  control_select_lo, serial_edge_choice, pulse_shape_pin,
                  path_operation_straps, tx_clock_loss_mask};
    c_n.pin_s2 = c_q.pin_s1;
    c_n.tog_s1 = l_q.tog;
    c_n.tog_s2 = c_q.tog_s1;
    c_n.tog_s3 = c_q.tog_s2;
    c_n.cfg_ack_s1 = l_q.req_s3;
    c_n.cfg_ack_s2 = c_q.cfg_ack_s1;

    // reset pin must stay low past the minimum before it takes effect
    if (p_rstn)
    begin
      c_n.rst_cnt = 8'h00;
      c_n.hw_rst  = 1'b0;
    end
    else if (c_q.rst_cnt > HW_RESET_CNT)
      c_n.hw_rst = 1'b1;
    else
      c_n.rst_cnt = c_q.rst_cnt + 8'h01;

    if (c_q.boot != 2'h0)
      c_n.boot = c_q.boot - 2'h1;

    // straps are caught only while reset holds, once the sync has settled
    if (c_q.boot != 2'h0 || c_q.hw_rst)
    begin
      unique case (p_sel)
        SEL_HW:     c_n.mode = E1TX_CTL_HW;
        SEL_SERIAL: c_n.mode = E1TX_CTL_SERIAL;
        SEL_MUX_DS: c_n.mode = E1TX_CTL_MUX_DS;
        SEL_MUX_RW: c_n.mode = E1TX_CTL_MUX_RW;
      endcase
    end

    // registers are writable only under software control
    if (reg_wr && sw_mode)
    begin
      if (reg_addr == TX_PATH_CONFIG_ZERO_OFS)
        c_n.tx_path_config_zero = reg_wdata;
      if (reg_addr == TX_PULSE_SHAPE_OFS)
        c_n.tcf1 = reg_wdata;
    end
    if (reg_addr == TX_PATH_CONFIG_ZERO_OFS)
      c_n.rdata = c_q.tx_path_config_zero;
    else if (reg_addr == TX_PULSE_SHAPE_OFS)
      c_n.rdata = c_q.tcf1;
    else
      c_n.rdata = 8'h00;

    if (sw_mode)
    begin
      c_n.cfg[CFG_RISE] = c_q.tx_path_config_zero[TX_CLOCK_EDGE_BIT];
      c_n.cfg[CFG_INV]  = c_q.tx_path_config_zero[TX_DATA_POL_BIT];
      c_n.cfg[CFG_DUAL] = c_q.tx_path_config_zero[TX_RAIL_MODE_BIT];
      c_n.cfg[CFG_AMI]  = c_q.tx_path_config_zero[TX_LINE_CODE_BIT];
      c_n.pmode         = c_q.tx_path_config_zero[TX_RAIL_MODE_BIT:TX_LINE_CODE_BIT];
      c_n.user_tpl      = (c_q.tcf1[3:2] == USER_TEMPLATE_CODE);
    end
    else
    begin
      c_n.cfg[CFG_RISE] = 1'b0;
      c_n.cfg[CFG_INV]  = 1'b0;
      c_n.cfg[CFG_DUAL] = p_path[1];
      c_n.cfg[CFG_AMI]  = p_path[0];
      c_n.pmode         = p_path;
      c_n.user_tpl      = p_pulse_shape_pin;
    end
    c_n.sfall = (c_q.mode == E1TX_CTL_SERIAL) && p_serial_edge_choice;

    // config crosses as a held word and a toggle that comes back as the
    // acknowledge, so the word never moves while the link may read it
    if (!c_q.irst && (c_q.cfg_req == c_q.cfg_ack_s2) &&
        (c_q.cfg_hold != c_q.cfg))
    begin
      c_n.cfg_hold = c_q.cfg;
      c_n.cfg_req  = ~c_q.cfg_req;
    end

    // counts master cycles since the last bit clock rising edge
    if (tx_edge)
      c_n.loss_cnt = 7'h00;
    else if (c_q.loss_cnt <= TX_CLK_LOSS_CYC)
      c_n.loss_cnt = c_q.loss_cnt + 7'h01;
    c_n.lost = (c_n.loss_cnt > TX_CLK_LOSS_CYC);
    c_n.irq  = c_n.lost && !p_mask;

    // float pin steers only the enable, never the encoder path
    c_n.oe = !p_float;

    c_n.irst = rst || c_q.hw_rst || (c_q.boot != 2'h0);

    if (rst || c_q.hw_rst)
    begin
      c_n.tx_path_config_zero     = TX_PATH_CONFIG_ZERO_RST;
      c_n.tcf1     = TX_PULSE_SHAPE_RST;
      c_n.loss_cnt = 7'h00;
      c_n.lost     = 1'b0;
      c_n.irq      = 1'b0;
      c_n.rdata    = 8'h00;
      c_n.cfg      = 4'h0;
      c_n.cfg_hold = 4'h0;
    end
    if (rst)
    begin
      c_n.boot    = BOOT_CYC;
      c_n.rst_cnt = 8'h00;
      c_n.hw_rst  = 1'b0;
      c_n.mode    = E1TX_CTL_HW;
      c_n.oe      = 1'b0;
      c_n.pmode   = 2'h0;
      c_n.sfall   = 1'b0;
      c_n.user_tpl = 1'b0;
      c_n.cfg_req  = 1'b0;
    end
  end

  always_ff @(posedge clk)
    c_q <= c_n;

  // falling-edge capture, read by the rising-edge stage half a bit later
  always_ff @(negedge tx_bit_clock)
    neg_cap <= {tx_data_pos_rail, tx_data_neg_rail};

  // link clock domain
  always_comb
  begin
    logic [1:0] raw;
    logic       lrst;
    lrst = l_q.rst_s2;
    raw  = l_q.cfg[CFG_RISE] ? {tx_data_pos_rail, tx_data_neg_rail}
                             : neg_cap;
    l_n = l_q;
    l_n.rst_s1 = c_q.irst;
    l_n.rst_s2 = l_q.rst_s1;
    l_n.req_s1 = c_q.cfg_req;
    l_n.req_s2 = l_q.req_s1;
    l_n.req_s3 = l_q.req_s2;
    l_n.tog    = ~l_q.tog;

    l_n.dat = raw ^ {2{l_q.cfg[CFG_INV]}};
    if (l_q.cfg[CFG_DUAL])
    begin
      // pos rail alone gives a negative pulse; equal rails give a space
      l_n.neg = l_q.dat[1] && !l_q.dat[0];
      l_n.pos = l_q.dat[0] && !l_q.dat[1];
    end
    else
    begin
      l_n.pos = cod_pos;
      l_n.neg = cod_neg;
    end
    if (lrst)
    begin
      l_n.dat = 2'h0;
      l_n.pos = 1'b0;
      l_n.neg = 1'b0;
      l_n.tog = 1'b0;
      l_n.cfg = 4'h0;
    end
    // the held word has stood still since its toggle left the master side
    if (l_q.req_s2 != l_q.req_s3)
      l_n.cfg = c_q.cfg_hold;
  end

  always_ff @(posedge tx_bit_clock)
    l_q <= l_n;

  // single rail takes the positive input only
  e1tx_line_coder u_coder (
    .clk       (tx_bit_clock),
    .rst       (l_q.rst_s2),
    .bit_in    (l_q.dat[1]),
    .ami_sel   (l_q.cfg[CFG_AMI]),
    .pulse_pos (cod_pos),
    .pulse_neg (cod_neg)
  );

  assign reg_rdata           = c_q.rdata;
  assign line_output_pos     = l_q.pos;
  assign line_output_neg     = l_q.neg;
  assign line_output_oe      = c_q.oe;
  assign internal_reset      = c_q.irst;
  assign ctl_mode            = c_q.mode;
  assign serial_fall_edge    = c_q.sfall;
  assign pulse_user_template = c_q.user_tpl;
  assign path_mode           = c_q.pmode;
  assign tx_clock_lost       = c_q.lost;
  assign tx_clock_loss_irq   = c_q.irq;

endmodule : e1tx_encoder
`default_nettype wire

// file: core/e1tx_line_coder.sv
// ami / hdb3 line coder running on the transmit bit clock
`timescale 1ns/10ps
`default_nettype none
module e1tx_line_coder
  import e1tx_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // data in
  input  wire logic bit_in,
  input  wire logic ami_sel,
  // symbol out
  output var  logic pulse_pos,
  output var  logic pulse_neg
);

  typedef struct packed {
    logic [1:0] s0;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] zcnt;
    logic       last_neg;
    logic       par;
    logic       pos;
    logic       neg;
  } e1tx_cod_t;

  e1tx_cod_t q;
  e1tx_cod_t n;

  // four-stage delay lets a b pulse be placed ahead of a zero run
  always_comb
  begin
    logic par_after;
    par_after = q.par;
    n = q;
    n.pos = 1'b0;
    n.neg = 1'b0;
    if (q.s3 == SYM_ONE || q.s3 == SYM_B)
    begin
      n.neg      = ~q.last_neg;
      n.pos      = q.last_neg;
      n.last_neg = ~q.last_neg;
      par_after  = ~q.par;
    end
    else if (q.s3 == SYM_V)
    begin
      n.neg     = q.last_neg;
      n.pos     = ~q.last_neg;
      par_after = 1'b0;
    end
    n.par = par_after;
    n.s3 = q.s2;
    n.s2 = q.s1;
    n.s1 = q.s0;
    n.s0 = bit_in ? SYM_ONE : SYM_ZERO;
    if (bit_in || ami_sel)
      n.zcnt = 2'h0;
    else if (q.zcnt == HDB3_RUN_LAST)
    begin
      n.s0   = SYM_V;
      n.zcnt = 2'h0;
      if (!par_after)
        n.s3 = SYM_B;
    end
    else
      n.zcnt = q.zcnt + 2'h1;
    if (rst)
      n = '0;
  end

  always_ff @(posedge clk)
    q <= n;

  assign pulse_pos = q.pos;
  assign pulse_neg = q.neg;

endmodule : e1tx_line_coder
`default_nettype wire

// file: core/e1tx_pkg.sv
// constants and types shared by the e1 transmit system-side encoder
//
// Overview of operation
// - reset pin held low longer than 100 ns forces the device into reset
// - float input low enables line driver; high floats the driver outputs
// - float input touches only the driver; encoder and clocking keep running
// - control straps: 00 pins, 01 serial, 10 mux data-strobe, 11 mux rd/wr
// - serial mode uses the edge choice input to pick the shift clock edge
// - bit clock absent over 70 master cycles raises interrupt unless masked
// - data sampled on the bit clock edge chosen by a config bit
// - a config bit chooses active-high or active-low transmit data
// - pin control mode always samples on falling edge, data active high
// - rail bit 0: single rail, data from the single data input only
// - rail bit 1: dual rail, symbols from both positive and negative inputs
// - single rail encodes hdb3 or ami per the line-code config bit
// - dual rail bypasses the encoder and sends sampled symbols to the line
// - dual rail: pos high neg low gives negative pulse, reverse gives positive
// - dual rail: equal rail inputs give a space with no pulse
// - pin control mode takes path operating mode from the path straps
// - pulse shape from preset or user template; registers or pin select it
package e1tx_pkg;

  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int HW_RESET_MIN_NS  = 100;
  localparam int HW_RESET_CYC     =
    (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HW_RESET_CNT = 8'(HW_RESET_CYC);
  localparam logic [6:0] TX_CLK_LOSS_CYC = 7'h46;
  localparam logic [1:0] BOOT_CYC = 2'h3;

  // register offsets
  localparam logic [7:0] TX_PATH_CONFIG_ZERO_OFS = 8'h05;
  localparam logic [7:0] TX_PULSE_SHAPE_OFS      = 8'h06;

  // field positions in tx_path_config_zero
  localparam int TX_LINE_CODE_BIT   = 0;
  localparam int TX_RAIL_MODE_BIT   = 1;
  localparam int TX_DATA_POL_BIT    = 4;
  localparam int TX_CLOCK_EDGE_BIT  = 5;
  localparam logic [1:0] USER_TEMPLATE_CODE = 2'h3;

  // reset values
  localparam logic [7:0] TX_PATH_CONFIG_ZERO_RST = 8'h00;
  localparam logic [7:0] TX_PULSE_SHAPE_RST      = 8'h00;

  // control select strap codes
  localparam logic [1:0] SEL_HW     = 2'h0;
  localparam logic [1:0] SEL_SERIAL = 2'h1;
  localparam logic [1:0] SEL_MUX_DS = 2'h2;
  localparam logic [1:0] SEL_MUX_RW = 2'h3;

  typedef enum logic [3:0] {
    E1TX_CTL_HW     = 4'h1,
    E1TX_CTL_SERIAL = 4'h2,
    E1TX_CTL_MUX_DS = 4'h4,
    E1TX_CTL_MUX_RW = 4'h8
  } e1tx_ctl_t;

  // symbols in the line coder pipeline
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_ONE  = 2'h1;
  localparam logic [1:0] SYM_B    = 2'h2;
  localparam logic [1:0] SYM_V    = 2'h3;
  localparam logic [1:0] HDB3_RUN_LAST = 2'h3;

endpackage : e1tx_pkg

// file: dv/e1tx_encoder_properties.sv
// port assertions for the e1 transmit encoder
`timescale 1ns/10ps
`default_nettype none
module e1tx_encoder_properties
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // pins
  input wire logic       hw_reset_n,
  input wire logic       driver_float_enable,
  input wire logic       control_select_hi,
  input wire logic       control_select_lo,
  input wire logic       serial_edge_choice,
  input wire logic       tx_clock_loss_mask,
  input wire logic       tx_bit_clock,
  // outputs
  input wire logic       line_output_pos,
  input wire logic       line_output_neg,
  input wire logic       line_output_oe,
  input wire logic       internal_reset,
  input wire logic [3:0] ctl_mode,
  input wire logic       serial_fall_edge,
  input wire logic       tx_clock_lost,
  input wire logic       tx_clock_loss_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // clk cycles since the last bit clock rise; sync delay allowed below
  logic       tbc_r;
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  always_comb
  begin
    if (internal_reset || (tx_bit_clock && !tbc_r))
      gap_nxt = 8'h00;
    else if (gap_r != 8'hff)
      gap_nxt = gap_r + 8'h01;
    else
      gap_nxt = gap_r;
  end
  always_ff @(posedge clk)
  begin
    tbc_r <= tx_bit_clock;
    gap_r <= rst ? 8'h00 : gap_nxt;
  end
  a_reset_pin: assert property (
    !hw_reset_n [*8] ##1 !hw_reset_n [*8] |-> ##[0:4] internal_reset)
    else $error("reset pin ignored");
  a_float_off: assert property (
    $rose(driver_float_enable) |-> ##[1:4] !line_output_oe)
    else $error("driver not floated");
  a_float_on: assert property (
    (!driver_float_enable && !internal_reset) [*5] |-> line_output_oe)
    else $error("driver not enabled");
  a_ctl_decode: assert property (
    !internal_reset |->
    ctl_mode == (4'h1 << {control_select_hi, control_select_lo}))
    else $error("control mode wrong");
  a_serial_edge: assert property (
    (ctl_mode == 4'h2 && serial_edge_choice) [*5] |-> serial_fall_edge)
    else $error("serial edge wrong");
  a_loss_quiet: assert property (
    gap_r >= 8'h08 && gap_r <= 8'h44 |-> !tx_clock_lost)
    else $error("loss flagged early");
  a_loss_raise: assert property (
    gap_r >= 8'h4e |-> tx_clock_lost)
    else $error("loss not flagged");
  a_irq_raise: assert property (
    (tx_clock_lost && !tx_clock_loss_mask) [*4] |-> tx_clock_loss_irq)
    else $error("loss interrupt missing");
  a_irq_mask: assert property (
    tx_clock_loss_mask [*4] |-> !tx_clock_loss_irq)
    else $error("masked interrupt seen");
  a_pulse_excl: assert property (
    !(line_output_pos && line_output_neg))
    else $error("both pulse outputs high");
  c_lost: cover property ($rose(tx_clock_lost));
  c_serial: cover property (ctl_mode == 4'h2 && serial_fall_edge);
  c_float: cover property (!line_output_oe && !internal_reset);
endmodule : e1tx_encoder_properties
bind e1tx_encoder e1tx_encoder_properties i_e1tx_encoder_properties (
  .clk(clk), .rst(rst), .hw_reset_n(hw_reset_n),
  .driver_float_enable(driver_float_enable),
  .control_select_hi(control_select_hi),
  .control_select_lo(control_select_lo),
  .serial_edge_choice(serial_edge_choice),
  .tx_clock_loss_mask(tx_clock_loss_mask), .tx_bit_clock(tx_bit_clock),
  .line_output_pos(line_output_pos), .line_output_neg(line_output_neg),
  .line_output_oe(line_output_oe), .internal_reset(internal_reset),
  .ctl_mode(ctl_mode), .serial_fall_edge(serial_fall_edge),
  .tx_clock_lost(tx_clock_lost), .tx_clock_loss_irq(tx_clock_loss_irq));
`default_nettype wire

// file: dv/e1tx_framer_model.sv
// framer stand-in driving the transmit bit clock and rail data
`timescale 1ns/10ps
`default_nettype none
module e1tx_framer_model
(
  // control from the bench
  input  wire logic run,
  input  wire logic samp_rise,
  input  wire logic pos_lvl,
  input  wire logic neg_lvl,
  // link side
  output var  logic tx_bit_clock,
  output var  logic tx_data_pos_rail,
  output var  logic tx_data_neg_rail
);
  // parks low when stopped; a 2.5 ns start keeps edges off the master clock
  initial
  begin
    tx_bit_clock = 1'b0;
    tx_data_pos_rail = 1'b0;
    tx_data_neg_rail = 1'b0;
    #2.5;
    forever
    begin
      #24;
      if (run || tx_bit_clock)
        tx_bit_clock = ~tx_bit_clock;
    end
  end
  // data moves on the edge opposite to the sampling one
  always @(tx_bit_clock)
  begin
    if (tx_bit_clock != samp_rise)
    begin
      tx_data_pos_rail = pos_lvl;
      tx_data_neg_rail = neg_lvl;
    end
  end
  // hold time is gone once stopped, so stale data is shown inverted
  always @(negedge run)
  begin
    tx_data_pos_rail = ~tx_data_pos_rail;
    tx_data_neg_rail = ~tx_data_neg_rail;
  end
endmodule : e1tx_framer_model
`default_nettype wire

// file: dv/test_e1tx_encoder.sv
// self-checking bench for the e1 transmit encoder
`timescale 1ns/10ps
`default_nettype none
module test_e1tx_encoder;
  import e1tx_pkg::*;
  typedef struct packed
  {
    logic [7:0] cfg;
    logic       p;
    logic       n;
    logic [7:0] ep;
    logic [7:0] en;
  } e1tx_row_t;
  // pulse counts over 16 bits for constant rail levels
  e1tx_row_t rows [9] = '{
    '{8'h02, 1'h1, 1'h0, 8'h00, 8'h10},
    '{8'h02, 1'h0, 1'h1, 8'h10, 8'h00},
    '{8'h02, 1'h1, 1'h1, 8'h00, 8'h00},
    '{8'h02, 1'h0, 1'h0, 8'h00, 8'h00},
    '{8'h12, 1'h1, 1'h0, 8'h10, 8'h00},
    '{8'h22, 1'h0, 1'h1, 8'h10, 8'h00},
    '{8'h01, 1'h1, 1'h1, 8'h08, 8'h08},
    '{8'h00, 1'h0, 1'h1, 8'h04, 8'h04},
    '{8'h01, 1'h0, 1'h0, 8'h00, 8'h00}};
  logic clk, rst, hw_reset_n, flt, sel_hi, sel_lo, sel_edge, pulse_pin;
  logic mask, reg_wr, pos_r, neg_r, lpos, lneg, oe, ireset, sfe, put;
  logic lost, irq, m_run, m_rise, m_pos, m_neg, tbc;
  logic [1:0] straps, pmode;
  logic [3:0] cmode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, p, n;
  int err_total, compares;
  e1tx_framer_model i_e1tx_framer_model (.run(m_run), .samp_rise(m_rise),
    .pos_lvl(m_pos), .neg_lvl(m_neg), .tx_bit_clock(tbc),
    .tx_data_pos_rail(pos_r), .tx_data_neg_rail(neg_r));
  e1tx_encoder i_e1tx_encoder (.clk(clk), .rst(rst), .tx_bit_clock(tbc),
    .hw_reset_n(hw_reset_n), .driver_float_enable(flt),
    .control_select_hi(sel_hi), .control_select_lo(sel_lo),
    .serial_edge_choice(sel_edge), .pulse_shape_pin(pulse_pin),
    .path_operation_straps(straps), .tx_clock_loss_mask(mask),
    .tx_data_pos_rail(pos_r), .tx_data_neg_rail(neg_r), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .line_output_pos(lpos), .line_output_neg(lneg), .line_output_oe(oe),
    .internal_reset(ireset), .ctl_mode(cmode), .serial_fall_edge(sfe),
    .pulse_user_template(put), .path_mode(pmode), .tx_clock_lost(lost),
    .tx_clock_loss_irq(irq));
  // master clock never stops, reset included
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    repeat (2) @(negedge clk);
    v = reg_rdata;
  endtask : rd
  task automatic reset_dut();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
  endtask : reset_dut
  // settle 20 bits, then count pulses over 16, sampled a quarter bit after the rise
  task automatic count(output logic [7:0] cp, output logic [7:0] cn);
    cp = 8'h00;
    cn = 8'h00;
    repeat (20) @(posedge tbc);
    repeat (16)
    begin
      @(posedge tbc);
      #12;
      cp = cp + {7'h00, lpos};
      cn = cn + {7'h00, lneg};
    end
    @(negedge clk);
  endtask : count
  task automatic complete_run();
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    #400000;
    err_total++;
    complete_run();
  end
  initial
  begin
    {hw_reset_n, flt, sel_hi, sel_lo, sel_edge, pulse_pin} = 6'h24;
    {mask, reg_wr, m_run, m_rise, m_pos, m_neg} = 6'h08;
    {straps, reg_addr, reg_wdata} = 18'h00000;
    err_total = 0;
    compares = 0;
    rst = 1'b1;
    @(negedge clk);
    reset_dut();
    foreach (rows[i])
    begin
      m_rise = rows[i].cfg[5];
      m_pos = rows[i].p;
      m_neg = rows[i].n;
      wr(8'h05, rows[i].cfg);
      rd(8'h05, d);
      chk("config", rows[i].cfg, d);
      count(p, n);
      chk("pos pulses", rows[i].ep, p);
      chk("neg pulses", rows[i].en, n);
    end
    rd(8'h07, d);
    chk("unmapped", 8'h00, d);
    m_pos = 1'b1;
    flt = 1'b1;
    count(p, n);
    chk("oe floated", 8'h00, {7'h00, oe});
    chk("float pulses", 8'h10, p + n);
    flt = 1'b0;
    repeat (6) @(negedge clk);
    chk("oe driving", 8'h01, {7'h00, oe});
    wr(8'h06, 8'h0c);
    repeat (4) @(negedge clk);
    chk("user template", 8'h01, {7'h00, put});
    m_run = 1'b0;
    repeat (100) @(negedge clk);
    chk("lost", 8'h03, {6'h00, lost, irq});
    mask = 1'b1;
    repeat (5) @(negedge clk);
    chk("masked", 8'h02, {6'h00, lost, irq});
    mask = 1'b0;
    m_run = 1'b1;
    repeat (20) @(negedge clk);
    chk("regained", 8'h00, {6'h00, lost, irq});
    hw_reset_n = 1'b0;
    repeat (5) @(negedge clk);
    hw_reset_n = 1'b1;
    repeat (8) @(negedge clk);
    rd(8'h05, d);
    chk("short pulse", 8'h01, d);
    hw_reset_n = 1'b0;
    repeat (20) @(negedge clk);
    chk("pin reset", 8'h01, {7'h00, ireset});
    hw_reset_n = 1'b1;
    repeat (8) @(negedge clk);
    rd(8'h05, d);
    chk("cleared", 8'h00, d);
    {straps, pulse_pin, sel_edge, m_rise, m_pos, m_neg} = 7'h59;
    for (int c = 3; c >= 0; c--)
    begin
      {sel_hi, sel_lo} = 2'(c);
      reset_dut();
      chk("ctl mode", 8'h01 << c, {4'h0, cmode});
      chk("serial edge", {7'h00, c == 1}, {7'h00, sfe});
      wr(8'h05, 8'h02);
      rd(8'h05, d);
      chk("hw refusal", (c == 0) ? 8'h00 : 8'h02, d);
    end
    chk("path mode", 8'h02, {6'h00, pmode});
    chk("pin template", 8'h01, {7'h00, put});
    count(p, n);
    chk("hw pulses", 8'h10, p);
    complete_run();
  end
endmodule : test_e1tx_encoder
`default_nettype wire
